// *** atrs_pkg.sv ***
// Constants for the address learning table read-out and status block.
// Assumes a 100 MHz clock and APB access with one word per register.
// Notes on behaviour
// - Scan command clears the entry-valid flag
// - Valid flag sets when entry found
// - No entry found leaves valid cleared
// - End-of-table flag set at table end
// - Valid may accompany end-of-table either way
// - Read-data registers load only from scans
// - Static bit exempts entry from aging
// - Inactive means no matching source address
// - Filter bit drops matching destination packets
// - Priority applies with entry and global enable
// - Bit 18 selects single or multiple ports
// - Port field encoding, 011 reserved
// - Bits 15:0 hold last MAC bits
// - Init table after reset, set done
// - Init lasts about 20us, drop packets
// - Init done reads 0, then self-sets
// - Make pending set during make, self-clears
// - Lower register holds first 32 MAC bits
package atrs_pkg;
    // Register numbers are word indices; the bus carries byte addresses
    localparam logic [15:0] IDX_LOWER = 16'h1805;
    localparam logic [15:0] IDX_UPPER = 16'h1806;
    localparam logic [15:0] IDX_STATUS = 16'h1808;
    localparam logic [15:0] ADDR_LOWER = 16'(IDX_LOWER << 2);
    localparam logic [15:0] ADDR_UPPER = 16'(IDX_UPPER << 2);
    localparam logic [15:0] ADDR_STATUS = 16'(IDX_STATUS << 2);
    localparam int BIT_VALID = 26;
    localparam int BIT_END = 25;
    localparam int BIT_STATIC = 24;
    localparam int BIT_FILTER = 23;
    localparam int BIT_PRI_EN = 22;
    localparam int BIT_PRI_LO = 19;
    localparam int BIT_PORT_LO = 16;
    localparam int BIT_INIT_DONE = 1;
    localparam int BIT_MAKE_PEND = 0;
    localparam logic [31:0] UPPER_RESET = 32'h0000_0000;
    localparam logic [31:0] LOWER_RESET = 32'h0000_0000;
    localparam int CLK_MHZ = 100;
    localparam int INIT_TIME_US = 20;
    localparam int INIT_CYCLES = INIT_TIME_US * CLK_MHZ;
    localparam logic [2:0] PORT_RESERVED = 3'h3;
    typedef enum logic [1:0] {
        ATRS_IDLE = 2'b00,
        ATRS_WAIT = 2'b01
    } atrs_scan_t;
endpackage : atrs_pkg

// *** atrs_top.sv ***
// Read-out and status registers of the address learning table.
// Assumes a table engine that answers scan commands with an entry strobe.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
module atrs_top
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic scan_first,
    input wire logic scan_next,
    input wire logic entry_strobe,
    input wire logic entry_found,
    input wire logic entry_last,
    input wire logic [63:0] entry_data,
    input wire logic make_start,
    input wire logic make_done,
    input wire logic da_highest_priority,
    output logic [2:0] dest_port_mask,
    output logic dest_multi_port,
    output logic dest_filter,
    output logic dest_pri_apply,
    output logic [2:0] dest_priority,
    output logic init_busy,
    output logic rx_drop
);
    import atrs_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    logic [31:0] upper_reg;
    logic [31:0] lower_reg;
    logic init_done_reg;
    logic make_pend_reg;
    logic [15:0] init_cnt_reg;
    atrs_scan_t scan_reg;
    logic [31:0] rdata_next;
    logic access;

    function automatic logic [2:0] port_decode(input logic [2:0] f);
        case (f)
            3'h0: port_decode = 3'h1;
            3'h1: port_decode = 3'h2;
            3'h2: port_decode = 3'h4;
            3'h4: port_decode = 3'h3;
            3'h5: port_decode = 3'h5;
            3'h6: port_decode = 3'h6;
            3'h7: port_decode = 3'h7;
            default: port_decode = 3'h0;
        endcase
    endfunction : port_decode

    ////////////////////////////////////////////////////////////////////////
    // Scan tracker; a fresh command outranks a stale answer in the same cycle
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            scan_reg <= ATRS_IDLE;
        else if (scan_first || scan_next)
            scan_reg <= ATRS_WAIT;
        else if (entry_strobe)
            scan_reg <= ATRS_IDLE;
        else
            scan_reg <= scan_reg;
    end

    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            upper_reg <= UPPER_RESET;
            lower_reg <= LOWER_RESET;
        end
        else if (scan_first || scan_next)
        begin
            upper_reg[BIT_VALID] <= 1'b0;
            upper_reg[BIT_END] <= 1'b0;
        end
        else if (entry_strobe && scan_reg == ATRS_WAIT)
        begin
            upper_reg[31:27] <= 5'h00;
            upper_reg[BIT_VALID] <= entry_found;
            upper_reg[BIT_END] <= entry_last;
            upper_reg[24:0] <= entry_data[56:32];
            lower_reg <= entry_data[31:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Table initialization after reset; packets drop until it finishes
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            init_cnt_reg <= 16'h0000;
            init_done_reg <= 1'b0;
        end
        else if (!init_done_reg)
        begin
            if (init_cnt_reg == 16'(INIT_CYCLES - 1))
                init_done_reg <= 1'b1;
            init_cnt_reg <= init_cnt_reg + 16'h0001;
        end
    end

    assign init_busy = !init_done_reg;
    assign rx_drop = !init_done_reg;

    // Start wins over done so a back-to-back make is never missed
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            make_pend_reg <= 1'b0;
        else if (make_start)
            make_pend_reg <= 1'b1;
        else if (make_done)
            make_pend_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Forwarding view of the entry last read out
    assign dest_port_mask = port_decode(upper_reg[18:16]);
    assign dest_multi_port = upper_reg[BIT_PORT_LO + 2];
    assign dest_filter = upper_reg[BIT_FILTER];
    assign dest_pri_apply = upper_reg[BIT_PRI_EN] && da_highest_priority;
    assign dest_priority = upper_reg[21:19];

    ////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, writes ignored, unmapped reads and writes error
    assign access = psel && penable;
    assign pready = 1'b1;

    always_comb
    begin
        rdata_next = 32'h0000_0000;
        case (paddr)
            ADDR_LOWER: rdata_next = lower_reg;
            ADDR_UPPER: rdata_next = upper_reg;
            ADDR_STATUS: rdata_next = {30'h0, init_done_reg, make_pend_reg};
            default: rdata_next = 32'h0000_0000;
        endcase
    end

    assign prdata = rdata_next;
    assign pslverr = access && !(paddr == ADDR_LOWER || paddr == ADDR_UPPER
        || paddr == ADDR_STATUS);

    ////////////////////////////////////////////////////////////////////////
    AST_CMD_CLEARS_VALID: assert property (@(posedge clk) disable iff (!rst_n)
        (scan_first || scan_next) |=> !upper_reg[BIT_VALID])
        else $error("valid not cleared by scan command");
    AST_VALID_ON_FOUND: assert property (@(posedge clk) disable iff (!rst_n)
        (scan_reg == ATRS_WAIT && entry_strobe && entry_found && !scan_first && !scan_next)
        |=> upper_reg[BIT_VALID])
        else $error("valid not set on found entry");
    AST_NOT_FOUND: assert property (@(posedge clk) disable iff (!rst_n)
        (scan_reg == ATRS_WAIT && entry_strobe && !entry_found)
        |=> !upper_reg[BIT_VALID])
        else $error("valid set without entry");
    AST_END_FLAG: assert property (@(posedge clk) disable iff (!rst_n)
        (scan_reg == ATRS_WAIT && entry_strobe && entry_last && !scan_first && !scan_next)
        |=> upper_reg[BIT_END])
        else $error("end flag missing");
    AST_LOAD_ONLY_SCAN: assert property (@(posedge clk) disable iff (!rst_n)
        !(entry_strobe && scan_reg == ATRS_WAIT) |=> $stable(lower_reg))
        else $error("lower readout changed without scan");
    AST_PRI_APPLY: assert property (@(posedge clk) disable iff (!rst_n)
        dest_pri_apply == (upper_reg[BIT_PRI_EN] && da_highest_priority))
        else $error("priority applied wrongly");
    AST_PORT_RESERVED: assert property (@(posedge clk) disable iff (!rst_n)
        (upper_reg[18:16] == PORT_RESERVED) |-> dest_port_mask == 3'h0)
        else $error("reserved port code decoded");
    AST_INIT_LOW: assert property (@(posedge clk)
        !rst_n |=> !init_done_reg [*8])
        else $error("init done early");
    AST_INIT_SETS: assert property (@(posedge clk) disable iff (!rst_n)
        (init_cnt_reg == 16'(INIT_CYCLES - 1) && !init_done_reg) |=> init_done_reg)
        else $error("init done not set");
    AST_MAKE_PEND: assert property (@(posedge clk) disable iff (!rst_n)
        make_start |=> make_pend_reg)
        else $error("make pending not set");
    AST_RSVD_ZERO: assert property (@(posedge clk) disable iff (!rst_n)
        upper_reg[31:27] == 5'h00)
        else $error("reserved upper bits set");
endmodule : atrs_top

// *** atrs_top_bench.sv ***
// Bench for the address table read-out and status block.
// Assumes zero-wait APB and stands in for the table engine and command logic.
`timescale 1ns/1ps
module atrs_top_bench;
    import atrs_pkg::*;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
    logic scan_first, scan_next, entry_strobe, entry_found, entry_last;
    logic make_start, make_done, da_highest_priority, dest_multi_port;
    logic dest_filter, dest_pri_apply, init_busy, rx_drop;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd, u;
    logic [63:0] entry_data;
    logic [2:0] dest_port_mask, dest_priority;
    int failures = 0;
    int num_checks = 0;
    // Expected port set per code, code 0 in the low three bits
    localparam logic [23:0] MASKS = 24'hfab111;
    atrs_top DUT (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scan_first(scan_first), .scan_next(scan_next), .entry_strobe(entry_strobe),
        .entry_found(entry_found), .entry_last(entry_last), .entry_data(entry_data),
        .make_start(make_start), .make_done(make_done),
        .da_highest_priority(da_highest_priority), .dest_port_mask(dest_port_mask),
        .dest_multi_port(dest_multi_port), .dest_filter(dest_filter),
        .dest_pri_apply(dest_pri_apply), .dest_priority(dest_priority),
        .init_busy(init_busy), .rx_drop(rx_drop));
////////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (failures == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        @(posedge clk);
        // Bounded so a stuck slave ends in a mismatch, not a hang
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk);
        end
        if (pready !== 1'b1)
            failures++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic cmd(input logic first);
        @(posedge clk);
        scan_first <= first;
        scan_next <= ~first;
        @(posedge clk);
        scan_first <= 1'b0;
        scan_next <= 1'b0;
    endtask : cmd
    task automatic strobe(input logic f, input logic l, input logic [63:0] d);
        @(posedge clk);
        entry_strobe <= 1'b1;
        entry_found <= f;
        entry_last <= l;
        entry_data <= d;
        @(posedge clk);
        entry_strobe <= 1'b0;
    endtask : strobe
////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        #200000;
        failures++;
        close_out;
    end
    initial
    begin
        {psel, penable, pwrite, scan_first, scan_next, entry_strobe} = '0;
        {entry_found, entry_last, make_start, make_done, da_highest_priority} = '0;
        paddr = '0;
        pwdata = '0;
        entry_data = '0;
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
        chk(rd, 32'h0);
        repeat (1990) @(posedge clk);
        chk({30'h0, init_busy, rx_drop}, 32'h3);
        repeat (15) @(posedge clk);
        chk({30'h0, init_busy, rx_drop}, 32'h0);
        apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
        chk(rd, 32'h2);
        cmd(1'b1);
        strobe(1'b1, 1'b0, 64'hfe5a_a5c3_1234_5678);
        apb(1'b0, ADDR_UPPER, 32'h0, rd, err);
        chk(rd, 32'h045a_a5c3);
        apb(1'b0, ADDR_LOWER, 32'h0, rd, err);
        chk(rd, 32'h1234_5678);
        cmd(1'b0);
        apb(1'b0, ADDR_UPPER, 32'h0, rd, err);
        chk(rd & 32'h0600_0000, 32'h0);
        strobe(1'b0, 1'b1, 64'h0);
        apb(1'b0, ADDR_UPPER, 32'h0, rd, err);
        chk(rd, 32'h0200_0000);
        strobe(1'b1, 1'b1, '1);
        apb(1'b1, ADDR_UPPER, 32'hffff_ffff, rd, err);
        apb(1'b0, ADDR_UPPER, 32'h0, rd, err);
        chk(rd, 32'h0200_0000);
        apb(1'b0, 16'h601c, 32'h0, rd, err);
        chk({err, rd[30:0]}, 32'h8000_0000);
        for (int i = 0; i < 8; i++)
        begin
            u = 32'hff00_beef | (32'(i) << 16) | (32'(i) << 19) | (32'(i & 3) << 22);
            da_highest_priority <= i[2];
            cmd(1'b0);
            strobe(1'b1, 1'b0, {u, 32'h0});
            apb(1'b0, ADDR_UPPER, 32'h0, rd, err);
            chk(rd, {5'h0, 2'b10, u[24:0]});
            chk({29'h0, dest_port_mask}, {29'h0, MASKS[i*3 +: 3]});
            chk({31'h0, dest_multi_port}, {31'h0, i[2]});
            chk({31'h0, dest_filter}, {31'h0, i[1]});
            chk({28'h0, dest_pri_apply, dest_priority}, {28'h0, i[0] & i[2], 3'(i)});
        end
        @(posedge clk);
        make_start <= 1'b1;
        @(posedge clk);
        make_start <= 1'b0;
        apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
        chk(rd, 32'h3);
        make_done <= 1'b1;
        @(posedge clk);
        make_done <= 1'b0;
        apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
        chk(rd, 32'h2);
        rst_n <= 1'b0;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        apb(1'b0, ADDR_STATUS, 32'h0, rd, err);
        chk(rd, 32'h0);
        apb(1'b0, ADDR_UPPER, 32'h0, rd, err);
        chk(rd, 32'h0);
        apb(1'b0, ADDR_LOWER, 32'h0, rd, err);
        chk(rd, 32'h0);
        chk({31'h0, rx_drop}, 32'h1);
        close_out;
    end
endmodule : atrs_top_bench
